// ==== lsct_pkg.sv ====
package lsct_pkg;

  // serial frame layout: address byte then data byte, msb first
  localparam int           SPI_BYTE_W        = 8;
  localparam int           SPI_FRAME_BITS    = 16;
  localparam int           SPI_READ_BIT      = 7;

  // register addresses
  localparam logic [6:0]   ADDR_OPERATING_MODE   = 7'h00;
  localparam logic [6:0]   ADDR_BIT_CLOCK_SKEW   = 7'h13;
  localparam logic [6:0]   ADDR_GAIN_CODE        = 7'h14;
  localparam logic [6:0]   ADDR_BLACK_LEVEL_HIGH = 7'h15;
  localparam logic [6:0]   ADDR_BLACK_LEVEL_LOW  = 7'h16;

  // reset values
  localparam logic [1:0]   RST_OPERATING_MODE    = 2'h0;
  localparam logic [5:0]   RST_BIT_CLOCK_SKEW    = 6'h00;
  localparam logic [4:0]   RST_GAIN_CODE         = 5'h10;
  localparam logic [3:0]   RST_BLACK_LEVEL_HIGH  = 4'h0;
  localparam logic [7:0]   RST_BLACK_LEVEL_LOW   = 8'h1F;

  // operating mode fields
  localparam int           MODE_SPEED_BIT    = 0;
  localparam int           MODE_WIDTH_BIT    = 1;

  // main clock and line timing
  localparam int           MCLK_PERIOD_NS    = 10;
  localparam int           HS_LINE_CYC       = 300;
  localparam int           HS_START_HIGH_CYC = 166;
  localparam int           LS_LINE_CYC       = 600;
  localparam int           LS_START_HIGH_CYC = 332;
  localparam int           HS_INTEG_TAIL_CYC = 106;
  localparam int           LS_INTEG_TAIL_CYC = 212;
  localparam int           HS_SYNC_DELAY_NS  = 930;
  localparam int           LS_SYNC_DELAY_NS  = 1870;
  localparam int           HS_SYNC_DELAY_CYC = HS_SYNC_DELAY_NS / MCLK_PERIOD_NS;
  localparam int           LS_SYNC_DELAY_CYC = LS_SYNC_DELAY_NS / MCLK_PERIOD_NS;
  localparam int           SYNC_WIDTH_CYC    = 4;

  // output format per mode
  localparam logic [4:0]   PAIRS_FULL        = 5'h10;
  localparam logic [4:0]   PAIRS_HALF        = 5'h08;
  localparam logic [3:0]   ADC_BITS_HS       = 4'hA;
  localparam logic [3:0]   ADC_BITS_LS       = 4'hB;
  localparam logic [11:0]  FULL_RANGE_HS     = 12'h400;
  localparam logic [11:0]  FULL_RANGE_LS     = 12'h800;
  localparam logic [13:0]  SKEW_STEP_PS      = 14'h0096;
  localparam int           BLACK_LEVEL_BITS  = 10;

endpackage

// ==== lsct_sync2.sv ====
`timescale 1ns/1ns
// two-stage synchroniser; the first stage feeds only the second
module lsct_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // not gated by the clock enable, so pins stay tracked while frozen
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// ==== lsct_spi_rx.sv ====
`timescale 1ns/1ns
// serial receiver running on the link clock
module lsct_spi_rx (
  // link pins
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  input  wire logic       config_reset_n_i,
  // captured words and their event toggles
  output logic [7:0]      addr_o,
  output logic            rd_tgl_o,
  output logic [7:0]      wdata_o,
  output logic            wr_tgl_o
);

  logic [4:0] bit_cnt_r;
  logic [6:0] shift_r;

  // the counter is cleared by chip select itself, since sclk stops after the frame
  always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i or negedge config_reset_n_i)
  begin
    if (!config_reset_n_i)
      bit_cnt_r <= 5'h00;
    else if (spi_cs_n_i)
      bit_cnt_r <= 5'h00;
    else if (bit_cnt_r != 5'(lsct_pkg::SPI_FRAME_BITS))
      bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  // msb first shift; extra edges past the frame are ignored
  always_ff @(posedge spi_sclk_i or negedge config_reset_n_i)
  begin
    if (!config_reset_n_i)
    begin
      shift_r  <= 7'h00;
      addr_o   <= 8'h00;
      wdata_o  <= 8'h00;
      rd_tgl_o <= 1'b0;
      wr_tgl_o <= 1'b0;
    end
    else if (!spi_cs_n_i)
    begin
      shift_r <= {shift_r[5:0], spi_mosi_i};
      if (bit_cnt_r == 5'(lsct_pkg::SPI_BYTE_W - 1))
      begin
        addr_o <= {shift_r, spi_mosi_i};
        if (shift_r[lsct_pkg::SPI_READ_BIT-1])
          rd_tgl_o <= ~rd_tgl_o;
      end
      if (bit_cnt_r == 5'(lsct_pkg::SPI_FRAME_BITS - 1) && !addr_o[lsct_pkg::SPI_READ_BIT])
      begin
        wdata_o  <= {shift_r, spi_mosi_i};
        wr_tgl_o <= ~wr_tgl_o;
      end
    end
  end

endmodule

// ==== lsct_top.sv ====
`timescale 1ns/1ns
module lsct_top #(
  parameter int PIXELS_PER_PORT = 256,
  parameter int PIX_W           = 8,
  parameter int TCNT_W          = 10,
  parameter int PCNT_W          = 12
) (
  // clock, reset, enable
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  // line control and configuration pins
  input  wire logic              line_start_pulse_i,
  input  wire logic              config_reset_n_i,
  // serial link
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_mosi_i,
  output logic                   spi_miso_o,
  // line timing
  output logic                   integrating_o,
  output logic                   line_sync_o,
  output logic                   pixel_valid_o,
  output logic [PIX_W-1:0]       pixel_index_o,
  output logic                   line_timing_error_o,
  // applied configuration
  output logic                   low_speed_o,
  output logic                   half_width_o,
  output logic [4:0]             active_pairs_o,
  output logic [3:0]             adc_bits_o,
  output logic [11:0]            full_range_dn_o,
  output logic [13:0]            bit_clock_delay_ps_o,
  output logic [4:0]             gain_factor_o,
  output logic [11:0]            black_level_o
);

  typedef enum logic [1:0] {LN_IDLE, LN_WAIT_SYNC, LN_SYNC, LN_VIDEO} lsct_line_e;

  // refuse sizes the counters cannot hold
  if (PIXELS_PER_PORT > (1 << PIX_W) || PIXELS_PER_PORT < 1)
    $error("pixel count does not fit the index width");
  if (lsct_pkg::LS_SYNC_DELAY_CYC >= (1 << TCNT_W))
    $error("timing counter too narrow for sync delay");
  if (lsct_pkg::LS_LINE_CYC >= (1 << PCNT_W))
    $error("period counter too narrow for line length");

  // decode a gain code into its factor; zero marks an illegal code
  function automatic logic [4:0] gain_factor(input logic [4:0] code);
    unique case (code)
      5'h00:   gain_factor = 5'h14;
      5'h01:   gain_factor = 5'h0A;
      5'h02:   gain_factor = 5'h08;
      5'h04:   gain_factor = 5'h04;
      5'h08:   gain_factor = 5'h02;
      5'h10:   gain_factor = 5'h01;
      default: gain_factor = 5'h00;
    endcase
  endfunction

  // synchronised pins and link events
  logic       lsp_s;
  logic       cfg_rst_n_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       rd_tgl_s;
  logic       wr_tgl_s;
  logic [7:0] spi_addr;
  logic [7:0] spi_wdata;
  logic       rd_tgl;
  logic       wr_tgl;

  lsct_spi_rx u_spi_rx (
    .spi_sclk_i       (spi_sclk_i),
    .spi_cs_n_i       (spi_cs_n_i),
    .spi_mosi_i       (spi_mosi_i),
    .config_reset_n_i (config_reset_n_i),
    .addr_o           (spi_addr),
    .rd_tgl_o         (rd_tgl),
    .wdata_o          (spi_wdata),
    .wr_tgl_o         (wr_tgl)
  );

  lsct_sync2 #(.WIDTH(6)) u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({line_start_pulse_i, config_reset_n_i, spi_sclk_i, spi_cs_n_i,
                 rd_tgl, wr_tgl}),
    .sync_o    ({lsp_s, cfg_rst_n_s, sclk_s, cs_n_s, rd_tgl_s, wr_tgl_s})
  );

  // edge history
  logic lsp_d_r;
  logic sclk_d_r;
  logic rd_tgl_d_r;
  logic wr_tgl_d_r;

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      lsp_d_r    <= 1'b0;
      sclk_d_r   <= 1'b0;
      rd_tgl_d_r <= 1'b0;
      wr_tgl_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      lsp_d_r    <= lsp_s;
      sclk_d_r   <= sclk_s;
      rd_tgl_d_r <= rd_tgl_s;
      wr_tgl_d_r <= wr_tgl_s;
    end
  end

  logic lsp_rise;
  logic lsp_fall;
  logic sclk_rise;
  logic rd_ev;
  logic wr_ev;
  logic cfg_clr;

  // link toggles are cleared by config reset, so mask events meanwhile
  assign lsp_rise  = lsp_s & ~lsp_d_r;
  assign lsp_fall  = ~lsp_s & lsp_d_r;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign cfg_clr   = ~cfg_rst_n_s;
  assign rd_ev     = (rd_tgl_s ^ rd_tgl_d_r) & cfg_rst_n_s;
  assign wr_ev     = (wr_tgl_s ^ wr_tgl_d_r) & cfg_rst_n_s;

  // shadow registers written by the link
  logic [1:0] mode_sh_r;
  logic [5:0] skew_sh_r;
  logic [4:0] gain_sh_r;
  logic [3:0] blh_sh_r;
  logic [7:0] bll_sh_r;

  // unmapped writes are dropped; illegal gain codes keep the old code
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      mode_sh_r <= lsct_pkg::RST_OPERATING_MODE;
      skew_sh_r <= lsct_pkg::RST_BIT_CLOCK_SKEW;
      gain_sh_r <= lsct_pkg::RST_GAIN_CODE;
      blh_sh_r  <= lsct_pkg::RST_BLACK_LEVEL_HIGH;
      bll_sh_r  <= lsct_pkg::RST_BLACK_LEVEL_LOW;
    end
    else if (ce_i)
    begin
      if (cfg_clr)
      begin
        mode_sh_r <= lsct_pkg::RST_OPERATING_MODE;
        skew_sh_r <= lsct_pkg::RST_BIT_CLOCK_SKEW;
        gain_sh_r <= lsct_pkg::RST_GAIN_CODE;
        blh_sh_r  <= lsct_pkg::RST_BLACK_LEVEL_HIGH;
        bll_sh_r  <= lsct_pkg::RST_BLACK_LEVEL_LOW;
      end
      else if (wr_ev)
      begin
        unique case (spi_addr[6:0])
          lsct_pkg::ADDR_OPERATING_MODE:   mode_sh_r <= spi_wdata[1:0];
          lsct_pkg::ADDR_BIT_CLOCK_SKEW:   skew_sh_r <= spi_wdata[5:0];
          lsct_pkg::ADDR_GAIN_CODE:
            if (gain_factor(spi_wdata[4:0]) != 5'h00)
              gain_sh_r <= spi_wdata[4:0];
          lsct_pkg::ADDR_BLACK_LEVEL_HIGH: blh_sh_r <= spi_wdata[3:0];
          lsct_pkg::ADDR_BLACK_LEVEL_LOW:  bll_sh_r <= spi_wdata;
          default: ;
        endcase
      end
    end
  end

  // applied settings, copied from the shadow only at a line start
  logic [1:0] mode_act_r;
  logic [5:0] skew_act_r;
  logic [4:0] gain_act_r;
  logic [3:0] blh_act_r;
  logic [7:0] bll_act_r;

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      mode_act_r <= lsct_pkg::RST_OPERATING_MODE;
      skew_act_r <= lsct_pkg::RST_BIT_CLOCK_SKEW;
      gain_act_r <= lsct_pkg::RST_GAIN_CODE;
      blh_act_r  <= lsct_pkg::RST_BLACK_LEVEL_HIGH;
      bll_act_r  <= lsct_pkg::RST_BLACK_LEVEL_LOW;
    end
    else if (ce_i)
    begin
      if (cfg_clr)
      begin
        mode_act_r <= lsct_pkg::RST_OPERATING_MODE;
        skew_act_r <= lsct_pkg::RST_BIT_CLOCK_SKEW;
        gain_act_r <= lsct_pkg::RST_GAIN_CODE;
        blh_act_r  <= lsct_pkg::RST_BLACK_LEVEL_HIGH;
        bll_act_r  <= lsct_pkg::RST_BLACK_LEVEL_LOW;
      end
      else if (lsp_rise)
      begin
        mode_act_r <= mode_sh_r;
        skew_act_r <= skew_sh_r;
        gain_act_r <= gain_sh_r;
        blh_act_r  <= blh_sh_r;
        bll_act_r  <= bll_sh_r;
      end
    end
  end

  logic low_speed;
  assign low_speed = mode_act_r[lsct_pkg::MODE_SPEED_BIT];

  // decoded configuration outputs, one cycle behind the applied values
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      low_speed_o          <= 1'b0;
      half_width_o         <= 1'b0;
      active_pairs_o       <= lsct_pkg::PAIRS_FULL;
      adc_bits_o           <= lsct_pkg::ADC_BITS_HS;
      full_range_dn_o      <= lsct_pkg::FULL_RANGE_HS;
      bit_clock_delay_ps_o <= 14'h0000;
      gain_factor_o        <= 5'h01;
      black_level_o        <= 12'h01F;
    end
    else if (ce_i)
    begin
      low_speed_o  <= low_speed;
      half_width_o <= mode_act_r[lsct_pkg::MODE_WIDTH_BIT];
      // half width in fast mode is the controller's error; passed as set
      active_pairs_o  <= mode_act_r[lsct_pkg::MODE_WIDTH_BIT] ?
                         lsct_pkg::PAIRS_HALF : lsct_pkg::PAIRS_FULL;
      adc_bits_o      <= low_speed ? lsct_pkg::ADC_BITS_LS
                                   : lsct_pkg::ADC_BITS_HS;
      full_range_dn_o <= low_speed ? lsct_pkg::FULL_RANGE_LS
                                   : lsct_pkg::FULL_RANGE_HS;
      bit_clock_delay_ps_o <= 14'(skew_act_r) * lsct_pkg::SKEW_STEP_PS;
      gain_factor_o <= gain_factor(gain_act_r);
      // top two bits forced clear so the code never exceeds 1023
      black_level_o <= {2'b00, blh_act_r[1:0], bll_act_r};
    end
  end

  // readback: the addressed value shifts out, one bit per sclk rise
  logic [7:0] rd_data;
  logic [6:0] rd_shift_r;
  logic [2:0] rd_left_r;

  always_comb
  begin
    rd_data = 8'h00;
    unique case (spi_addr[6:0])
      lsct_pkg::ADDR_OPERATING_MODE:   rd_data = {6'h00, mode_sh_r};
      lsct_pkg::ADDR_BIT_CLOCK_SKEW:   rd_data = {2'h0, skew_sh_r};
      lsct_pkg::ADDR_GAIN_CODE:        rd_data = {3'h0, gain_sh_r};
      lsct_pkg::ADDR_BLACK_LEVEL_HIGH: rd_data = {4'h0, blh_sh_r};
      lsct_pkg::ADDR_BLACK_LEVEL_LOW:  rd_data = bll_sh_r;
      default:                         rd_data = 8'h00;
    endcase
  end

  // shifting after the rise leaves a whole period before the next sample
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      spi_miso_o <= 1'b0;
      rd_shift_r <= 7'h00;
      rd_left_r  <= 3'h0;
    end
    else if (ce_i)
    begin
      if (cs_n_s || cfg_clr)
      begin
        spi_miso_o <= 1'b0;
        rd_left_r  <= 3'h0;
      end
      else if (rd_ev)
      begin
        spi_miso_o <= rd_data[7];
        rd_shift_r <= rd_data[6:0];
        rd_left_r  <= 3'h7;
      end
      else if (sclk_rise && rd_left_r != 3'h0)
      begin
        spi_miso_o <= rd_shift_r[6];
        rd_shift_r <= {rd_shift_r[5:0], 1'b0};
        rd_left_r  <= rd_left_r - 3'h1;
      end
    end
  end

  // integration window: from the fall of line start to a tail past its rise
  logic [TCNT_W-1:0] tail_cnt_r;
  logic              tail_run_r;
  logic [TCNT_W-1:0] tail_len;

  assign tail_len = low_speed ? TCNT_W'(lsct_pkg::LS_INTEG_TAIL_CYC)
                              : TCNT_W'(lsct_pkg::HS_INTEG_TAIL_CYC);

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      integrating_o <= 1'b0;
      tail_cnt_r    <= '0;
      tail_run_r    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (lsp_rise)
      begin
        tail_cnt_r <= '0;
        tail_run_r <= integrating_o | lsp_fall;
      end
      else if (tail_run_r)
      begin
        tail_cnt_r <= tail_cnt_r + 1'b1;
        if (tail_cnt_r == tail_len - 1'b1)
        begin
          integrating_o <= 1'b0;
          tail_run_r    <= 1'b0;
        end
      end
      if (lsp_fall) // set wins over a tail ending in the same cycle
        integrating_o <= 1'b1;
    end
  end

  // line sequencer: delay, sync pulse, then pixels in ascending order
  lsct_line_e        line_st_r;
  logic [TCNT_W-1:0] tcnt_r;
  logic [TCNT_W-1:0] sync_delay;

  assign sync_delay = low_speed ? TCNT_W'(lsct_pkg::LS_SYNC_DELAY_CYC)
                                : TCNT_W'(lsct_pkg::HS_SYNC_DELAY_CYC);

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      line_st_r     <= LN_IDLE;
      tcnt_r        <= '0;
      line_sync_o   <= 1'b0;
      pixel_valid_o <= 1'b0;
      pixel_index_o <= '0;
    end
    else if (ce_i)
    begin
      // a new line start always wins and restarts the sequence
      if (lsp_rise)
      begin
        line_st_r     <= LN_WAIT_SYNC;
        tcnt_r        <= '0;
        line_sync_o   <= 1'b0;
        pixel_valid_o <= 1'b0;
      end
      else
      begin
        unique case (line_st_r)
          LN_IDLE:
          begin
            pixel_valid_o <= 1'b0;
          end
          LN_WAIT_SYNC:
          begin
            tcnt_r <= tcnt_r + 1'b1;
            if (tcnt_r == sync_delay - 1'b1)
            begin
              line_st_r   <= LN_SYNC;
              tcnt_r      <= '0;
              line_sync_o <= 1'b1;
            end
          end
          LN_SYNC:
          begin
            tcnt_r <= tcnt_r + 1'b1;
            if (tcnt_r == TCNT_W'(lsct_pkg::SYNC_WIDTH_CYC - 1))
            begin
              line_st_r     <= LN_VIDEO;
              line_sync_o   <= 1'b0;
              pixel_valid_o <= 1'b1;
              pixel_index_o <= '0;
            end
          end
          LN_VIDEO:
          begin
            if (pixel_index_o == PIX_W'(PIXELS_PER_PORT - 1))
            begin
              line_st_r     <= LN_IDLE;
              pixel_valid_o <= 1'b0;
            end
            else
              pixel_index_o <= pixel_index_o + 1'b1;
          end
        endcase
      end
    end
  end

  // flags a line start that is shorter than the mode allows
  logic [PCNT_W-1:0] high_cnt_r;
  logic [PCNT_W-1:0] period_cnt_r;
  logic              seen_rise_r;
  logic [PCNT_W-1:0] min_high;
  logic [PCNT_W-1:0] min_period;

  assign min_high   = low_speed ? PCNT_W'(lsct_pkg::LS_START_HIGH_CYC)
                                : PCNT_W'(lsct_pkg::HS_START_HIGH_CYC);
  assign min_period = low_speed ? PCNT_W'(lsct_pkg::LS_LINE_CYC)
                                : PCNT_W'(lsct_pkg::HS_LINE_CYC);

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      high_cnt_r          <= '0;
      period_cnt_r        <= '0;
      seen_rise_r         <= 1'b0;
      line_timing_error_o <= 1'b0;
    end
    else if (ce_i)
    begin
      line_timing_error_o <= 1'b0;
      if (period_cnt_r != '1)
        period_cnt_r <= period_cnt_r + 1'b1;
      if (lsp_s && high_cnt_r != '1)
        high_cnt_r <= high_cnt_r + 1'b1;
      if (lsp_rise)
      begin
        high_cnt_r   <= PCNT_W'(1);
        period_cnt_r <= PCNT_W'(1);
        seen_rise_r  <= 1'b1;
        if (seen_rise_r && period_cnt_r < min_period)
          line_timing_error_o <= 1'b1;
      end
      else if (lsp_fall && seen_rise_r && high_cnt_r < min_high)
        line_timing_error_o <= 1'b1;
    end
  end

endmodule

// ==== lsct_top_monitor.sv ====
`timescale 1ns/1ns
// watches line timing and applied settings at the top ports
module lsct_top_monitor #(
  parameter int PIXELS_PER_PORT = 256,
  parameter int PIX_W           = 8
) (
  // clock and resets
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic             config_reset_n_i,
  // line timing
  input  wire logic             line_start_pulse_i,
  input  wire logic             integrating_o,
  input  wire logic             line_sync_o,
  input  wire logic             pixel_valid_o,
  input  wire logic [PIX_W-1:0] pixel_index_o,
  // applied configuration
  input  wire logic             low_speed_o,
  input  wire logic             half_width_o,
  input  wire logic [4:0]       active_pairs_o,
  input  wire logic [3:0]       adc_bits_o,
  input  wire logic [11:0]      full_range_dn_o,
  input  wire logic [13:0]      bit_clock_delay_ps_o,
  input  wire logic [4:0]       gain_factor_o,
  input  wire logic [11:0]      black_level_o
);
  // one domain only, so one clock and one disable
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ranges allow for the two-stage synchroniser on the pin
  a_sync_delay: assert property ($rose(line_start_pulse_i) |->
    ##[94:99] ($rose(line_sync_o) && !low_speed_o) or ##[188:193] ($rose(line_sync_o) && low_speed_o))
    else $error("line sync delay wrong");
  a_integ_tail: assert property ($rose(line_start_pulse_i) && integrating_o |->
    ##[107:112] ($fell(integrating_o) && !low_speed_o) or ##[213:218] ($fell(integrating_o) && low_speed_o))
    else $error("integration tail wrong");
  a_sync_video: assert property ($rose(line_sync_o) |->
    line_sync_o [*4] ##1 (!line_sync_o && pixel_valid_o && pixel_index_o == 0))
    else $error("video does not follow sync");
  a_pix_step: assert property (pixel_valid_o && $past(pixel_valid_o) |->
    pixel_index_o == $past(pixel_index_o) + 1'b1) else $error("pixel order broken");
  a_pix_count: assert property ($fell(pixel_valid_o) |->
    $past(pixel_index_o) == PIXELS_PER_PORT - 1) else $error("pixel count wrong");

  // derived format must follow the applied mode bits; gain, skew and black level must stay legal
  a_speed_fmt: assert property (low_speed_o ?
    (adc_bits_o == 4'hB && full_range_dn_o == 12'h800) :
    (adc_bits_o == 4'hA && full_range_dn_o == 12'h400)) else $error("speed format wrong");
  a_width_pairs: assert property (active_pairs_o == (half_width_o ? 5'h08 : 5'h10))
    else $error("pair count wrong");
  a_gain_legal: assert property (gain_factor_o inside {1, 2, 4, 8, 10, 20})
    else $error("gain factor illegal");
  a_skew_step: assert property (bit_clock_delay_ps_o % 150 == 0 && bit_clock_delay_ps_o <= 9450)
    else $error("skew delay off grid");
  a_black_top: assert property (black_level_o[11:10] == 2'b00)
    else $error("black level top bits set");

  // settings move only near a line start or under config reset
  a_cfg_at_line: assert property ($changed({low_speed_o, gain_factor_o, black_level_o}) &&
    config_reset_n_i |-> line_start_pulse_i && !$past(line_start_pulse_i, 8))
    else $error("setting changed mid line");
  a_cfg_reset: assert property ($fell(config_reset_n_i) ##1 !config_reset_n_i [*6] |->
    gain_factor_o == 5'h01 && black_level_o == 12'h01F) else $error("config reset ignored");
endmodule

bind lsct_top lsct_top_monitor #(.PIXELS_PER_PORT(PIXELS_PER_PORT), .PIX_W(PIX_W)) i_mon (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .config_reset_n_i(config_reset_n_i),
  .line_start_pulse_i(line_start_pulse_i), .integrating_o(integrating_o),
  .line_sync_o(line_sync_o), .pixel_valid_o(pixel_valid_o), .pixel_index_o(pixel_index_o),
  .low_speed_o(low_speed_o), .half_width_o(half_width_o), .active_pairs_o(active_pairs_o),
  .adc_bits_o(adc_bits_o), .full_range_dn_o(full_range_dn_o),
  .bit_clock_delay_ps_o(bit_clock_delay_ps_o), .gain_factor_o(gain_factor_o),
  .black_level_o(black_level_o));

// ==== lsct_ctrl_model.sv ====
`timescale 1ns/1ns
// camera controller: line start generator and serial master
module lsct_ctrl_model #(
  parameter int PERIOD = 600,
  parameter int HIGH   = 332
) (
  // main clock and line enable
  input  wire logic mclk_i,
  input  wire logic line_en_i,
  // pins toward the sensor
  output logic      line_start_pulse_o,
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o,
  input  wire logic spi_miso_i
);
  int               cnt_r = 0;

  // idle pins; sclk stands still low between frames
  initial
  begin
    line_start_pulse_o = 1'b0;
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // fixed period, high for the minimum part of it
  always @(posedge mclk_i)
  begin
    cnt_r <= (cnt_r == PERIOD - 1 || !line_en_i) ? 0 : cnt_r + 1;
    line_start_pulse_o <= line_en_i && cnt_r < HIGH;
  end

  // address then data msb first at 160 ns; odd offset keeps off mclk edges
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {a, d};
    #37 spi_cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi_o = w[i];
      #80 spi_sclk_o = 1'b1;
      if (i < 8)
        q[i] = spi_miso_i;
      #80 spi_sclk_o = 1'b0;
    end
    #80 spi_cs_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
    #160;
  endtask
endmodule

// ==== tb_lsct_top.sv ====
`timescale 1ns/1ns
// bench: serial setup, line timing and applied settings
module tb_lsct_top;
  logic        mclk_i, reset_n_i, config_reset_n_i, line_en, line_start_pulse_i;
  logic        spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, integrating_o;
  logic        line_sync_o, pixel_valid_o, line_timing_error_o, low_speed_o, half_width_o;
  logic [7:0]  pixel_index_o, q;
  logic [4:0]  active_pairs_o, gain_factor_o;
  logic [3:0]  adc_bits_o;
  logic [11:0] full_range_dn_o, black_level_o;
  logic [13:0] bit_clock_delay_ps_o;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n_terr = 0;
  // addresses, reset values, values written, gain codes and factors
  logic [7:0]  ra [5] = '{8'h00, 8'h13, 8'h14, 8'h15, 8'h16};
  logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h1F};
  logic [7:0]  wv [5] = '{8'h03, 8'h3F, 8'h04, 8'h0F, 8'hFF};
  logic [7:0]  gc [6] = '{8'h10, 8'h00, 8'h01, 8'h02, 8'h04, 8'h08};
  logic [4:0]  gf [6] = '{5'h01, 5'h14, 5'h0A, 5'h08, 5'h04, 5'h02};

  lsct_top i_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .line_start_pulse_i(line_start_pulse_i), .config_reset_n_i(config_reset_n_i),
    .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o), .integrating_o(integrating_o), .line_sync_o(line_sync_o),
    .pixel_valid_o(pixel_valid_o), .pixel_index_o(pixel_index_o),
    .line_timing_error_o(line_timing_error_o), .low_speed_o(low_speed_o),
    .half_width_o(half_width_o), .active_pairs_o(active_pairs_o), .adc_bits_o(adc_bits_o),
    .full_range_dn_o(full_range_dn_o), .bit_clock_delay_ps_o(bit_clock_delay_ps_o),
    .gain_factor_o(gain_factor_o), .black_level_o(black_level_o));

  // slow line timing is legal in either mode
  lsct_ctrl_model #(.PERIOD(600), .HIGH(332)) i_ctrl (
    .mclk_i(mclk_i), .line_en_i(line_en), .line_start_pulse_o(line_start_pulse_i),
    .spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i), .spi_mosi_o(spi_mosi_i),
    .spi_miso_i(spi_miso_o));

  // main clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // count line timing error pulses where they are settled
  always @(negedge mclk_i)
    if (line_timing_error_o === 1'b1)
      n_terr++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
      n_errors++;
    if (got !== exp)
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ctrl.xfer(a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_ctrl.xfer(a | 8'h80, 8'h00, q);
    chk(q, exp);
  endtask

  // wait out n lines, counting the pixels of each; bounded waits
  task automatic lines(input int n);
    int k;
    int npix;
    repeat (n)
    begin
      for (k = 0; line_sync_o !== 1'b1 && k < 2000; k++) @(negedge mclk_i);
      for (k = 0; pixel_valid_o !== 1'b1 && k < 20; k++) @(negedge mclk_i);
      for (npix = 0; pixel_valid_o === 1'b1 && npix < 2000; npix++) @(negedge mclk_i);
      chk(npix, 256);
    end
  endtask

  task automatic summarize;
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end

  initial
  begin
    reset_n_i <= 1'b0;
    config_reset_n_i <= 1'b0;
    line_en <= 1'b0;
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    config_reset_n_i <= 1'b1;
    repeat (8) @(negedge mclk_i);
    chk({active_pairs_o, adc_bits_o, full_range_dn_o}, {5'h10, 4'hA, 12'h400});
    chk({bit_clock_delay_ps_o, gain_factor_o, black_level_o}, {14'h0, 5'h01, 12'h01F});
    for (int i = 0; i < 5; i++)
      rd(ra[i], rv[i]);
    rd(8'h01, 8'h00);
    // slow half width; a bad gain code must be dropped
    for (int i = 0; i < 5; i++)
      wr(ra[i], wv[i]);
    wr(8'h14, 8'h03);
    for (int i = 0; i < 5; i++)
      rd(ra[i], wv[i]);
    chk(gain_factor_o, 5'h01);
    @(posedge mclk_i);
    line_en <= 1'b1;
    lines(2);
    chk({low_speed_o, half_width_o, active_pairs_o, adc_bits_o, full_range_dn_o},
        {2'b11, 5'h08, 4'hB, 12'h800});
    chk({bit_clock_delay_ps_o, gain_factor_o, black_level_o}, {14'h24EA, 5'h04, 12'h3FF});
    // fast full width, every legal gain code
    wr(8'h00, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h14, gc[i]);
      lines(2);
      chk(gain_factor_o, gf[i]);
    end
    chk({low_speed_o, half_width_o, active_pairs_o, adc_bits_o, full_range_dn_o},
        {2'b00, 5'h10, 4'hA, 12'h400});
    // lines stopped so the reset is the only cause of change
    @(posedge mclk_i);
    line_en <= 1'b0;
    repeat (700) @(posedge mclk_i);
    config_reset_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    config_reset_n_i <= 1'b1;
    repeat (4) @(negedge mclk_i);
    chk({bit_clock_delay_ps_o, gain_factor_o, black_level_o}, {14'h0, 5'h01, 12'h01F});
    rd(8'h16, 8'h1F);
    // a line start cut short must be flagged exactly once
    @(posedge mclk_i);
    line_en <= 1'b1;
    repeat (100) @(posedge mclk_i);
    line_en <= 1'b0;
    repeat (8) @(posedge mclk_i);
    chk(n_terr, 1);
    summarize();
  end
endmodule
